// >>> ibc_bus_ctrl.sv
// Control register and bus condition logic: stretching, acknowledge, start and stop
//
// Function
// - Stop detected with stop interrupt enabled raises the interrupt; disabled raises none.
// - Address match wakeup set suppresses the stop interrupt entirely.
// - Stretch timing 0: interrupt at 8th falling edge; master holds clock after 8.
// - Stretch timing 1: interrupt at 9th falling edge; master holds clock after 9.
// - Slave pulls clock low after 8 or 9 received pulses per stretch timing.
// - Address transfer interrupts at 9th fall, except an extension code at 8th; stretch timing applies afterwards.
// - Master stretches at the 9th falling edge of address transfer.
// - Addressed slave acknowledges first, then stretches at the 9th falling edge.
// - Slave receiving an extension code stretches at the 8th falling edge.
// - Acknowledge enable drives data low during the 9th clock; otherwise no acknowledge.
// - Start trigger on a free bus generates a start and makes us master.
// - Start trigger on a busy bus with reservation enabled waits, then starts.
// - Start trigger on a busy bus with reservation disabled is cleared, flag set.
// - Start trigger during master stretch releases it and makes a repeated start.
// - Start trigger clears on refusal, arbitration loss, start, exit, disable, reset.
// - Stop trigger set generates a stop and ends master transfer; zero does nothing.
// - Start trigger bit always reads as zero.
// - Acknowledge enable ignored in address transfer; matched slave always acknowledges.
`default_nettype none

`include "ibc_regs.svh"

module ibc_bus_ctrl #(
  parameter int HALF_CYC = `IBC_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire ibc_pkg::ibc_byte_type reg_wdata,
  output ibc_pkg::ibc_byte_type reg_rdata,
  input wire ibc_pkg::ibc_addr_type own_address,
  input wire logic addr_match_wakeup,
  input wire logic reservation_disable,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic irq,
  output logic bus_busy_flag,
  output logic start_clear_flag,
  output logic master_state
);
  import ibc_pkg::*;

  localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);

  // The synchronisers add two cycles of latency, so a half period must outlast them
  if (HALF_CYC < 8 || HALF_CYC > 65535) begin : g_check
    $error("HALF_CYC out of range");
  end

  ibc_line_if line ();

  ibc_line_sense u_sense (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .line(line.sense)
  );

  ibc_byte_type bus_control_zero_q;
  ibc_mstate_type m_state_q;
  logic [15:0] half_cnt_q;
  logic start_trigger_q;
  logic stop_trigger_q;
  logic start_clear_q;
  logic busy_q;
  logic master_q;
  logic [3:0] cnt_q;
  logic skip_q;
  logic addr_phase_q;
  ibc_byte_type shift_q;
  logic addressed_q;
  logic ext_q;
  logic ack_q;
  logic slv_hold_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic irq_q;
  logic pin_low_q;
  ibc_byte_type rdata_q;

  logic op_en;
  logic stop_irq_enable;
  logic stretch_timing_select;
  logic ack_enable;
  logic wr_start;
  logic wr_stop;
  logic exit_req;
  logic release_req;
  logic refuse;
  logic go_start;
  logic arb_lost;
  logic enter_start;
  logic stop_go;
  logic half_done;
  logic fall_ok;
  logic [3:0] n;
  logic addr_match;
  logic ext_match;
  logic slave_hit_now;
  logic irq_point;
  logic ext_point;
  logic stretch_evt;
  logic scl_oe_d;
  logic sda_oe_d;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  assign op_en = bus_control_zero_q[`IBC_BIT_ENABLE];
  assign stop_irq_enable = bus_control_zero_q[`IBC_BIT_STOP_IRQ];
  assign stretch_timing_select = bus_control_zero_q[`IBC_BIT_STRETCH];
  assign ack_enable = bus_control_zero_q[`IBC_BIT_ACK];

  // Action bits are ignored while operation is off
  assign wr_start = reg_wr_en & reg_wdata[`IBC_BIT_START] & op_en;
  assign wr_stop = reg_wr_en & reg_wdata[`IBC_BIT_STOP] & op_en;
  assign exit_req = reg_wr_en & reg_wdata[`IBC_BIT_EXIT] & op_en;
  assign release_req = reg_wr_en & reg_wdata[`IBC_BIT_RELEASE] & op_en;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_control_zero_q <= `IBC_CTL0_RESET;
    end else if (reg_wr_en) begin
      bus_control_zero_q <= reg_wdata & `IBC_CTL0_STORED;
    end
  end

  // Trigger, exit and release bits are never stored, so they read back as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `IBC_CTL0_RESET;
    end else begin
      rdata_q <= bus_control_zero_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start and stop trigger handling
  assign refuse = wr_start & busy_q & reservation_disable & (m_state_q != M_STRETCH);
  assign go_start = start_trigger_q & ~busy_q & (m_state_q == M_IDLE);
  // Someone else already holds a line at the moment we would start
  assign arb_lost = go_start & ~(line.scl_s & line.sda_s);
  assign half_done = (half_cnt_q == HALF_LAST);
  assign enter_start = (go_start & ~arb_lost) | ((m_state_q == M_RESTART) & half_done);
  assign stop_go = stop_trigger_q & (m_state_q == M_STRETCH);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_trigger_q <= 1'b0;
    end else if (!op_en || exit_req || arb_lost || enter_start || refuse) begin
      start_trigger_q <= 1'b0;
    end else if (wr_start) begin
      start_trigger_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_clear_q <= 1'b0;
    end else if (!op_en) begin
      start_clear_q <= 1'b0;
    end else if (refuse) begin
      start_clear_q <= 1'b1;
    end else if (wr_start) begin
      start_clear_q <= 1'b0;
    end
  end

  // A stop request waits for the next master stretch before it acts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_trigger_q <= 1'b0;
    end else if (!op_en || exit_req) begin
      stop_trigger_q <= 1'b0;
    end else if (wr_stop) begin
      stop_trigger_q <= 1'b1;
    end else if (stop_go || line.stop_det) begin
      stop_trigger_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (!op_en) begin
      busy_q <= 1'b0;
    end else if (line.start_det) begin
      busy_q <= 1'b1;
    end else if (line.stop_det) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      master_q <= 1'b0;
    end else if (!op_en || exit_req || arb_lost || line.stop_det) begin
      master_q <= 1'b0;
    end else if (enter_start) begin
      master_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock generator
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_state_q <= M_IDLE;
      half_cnt_q <= 16'h0000;
    end else if (!op_en || exit_req || arb_lost) begin
      m_state_q <= M_IDLE;
      half_cnt_q <= 16'h0000;
    end else begin
      unique case (m_state_q)
        M_IDLE: begin
          half_cnt_q <= 16'h0000;
          if (go_start) begin
            m_state_q <= M_START;
          end
        end
        M_START: begin
          half_cnt_q <= half_done ? 16'h0000 : half_cnt_q + 16'h0001;
          if (half_done) begin
            m_state_q <= M_LOW;
          end
        end
        M_LOW: begin
          half_cnt_q <= half_done ? 16'h0000 : half_cnt_q + 16'h0001;
          if (stretch_evt) begin
            m_state_q <= M_STRETCH;
          end else if (half_done) begin
            m_state_q <= M_HIGH;
          end
        end
        M_HIGH: begin
          // The high half only counts once the line is seen high, so a slave may stretch
          if (half_done) begin
            m_state_q <= M_LOW;
            half_cnt_q <= 16'h0000;
          end else if (line.scl_s) begin
            half_cnt_q <= half_cnt_q + 16'h0001;
          end
        end
        M_STRETCH: begin
          half_cnt_q <= 16'h0000;
          if (stop_go) begin
            m_state_q <= M_STOP_L;
          end else if (wr_start) begin
            m_state_q <= M_RESTART;
          end else if (release_req) begin
            m_state_q <= M_LOW;
          end
        end
        M_RESTART: begin
          if (half_done) begin
            m_state_q <= M_START;
            half_cnt_q <= 16'h0000;
          end else if (line.scl_s) begin
            half_cnt_q <= half_cnt_q + 16'h0001;
          end
        end
        M_STOP_L: begin
          half_cnt_q <= half_done ? 16'h0000 : half_cnt_q + 16'h0001;
          if (half_done) begin
            m_state_q <= M_STOP_H;
          end
        end
        M_STOP_H: begin
          if (half_done) begin
            m_state_q <= M_IDLE;
            half_cnt_q <= 16'h0000;
          end else if (line.scl_s) begin
            half_cnt_q <= half_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock counting and address recognition, shared by master and slave
  assign n = (cnt_q == `IBC_FALL_ACK) ? 4'h1 : cnt_q + 4'h1;
  assign fall_ok = line.scl_fall & ~skip_q;
  assign addr_match = (shift_q[7:1] == own_address);
  assign ext_match = (shift_q[7:3] == `IBC_EXT_CODE);
  assign slave_hit_now = addr_phase_q & ~master_q & (addr_match | ext_match);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      skip_q <= 1'b0;
      addr_phase_q <= 1'b0;
      shift_q <= 8'h00;
      addressed_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (!op_en || exit_req) begin
      cnt_q <= 4'h0;
      skip_q <= 1'b0;
      addr_phase_q <= 1'b0;
      addressed_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (line.start_det) begin
      // The falling clock that closes a start is not a data clock
      cnt_q <= 4'h0;
      skip_q <= 1'b1;
      addr_phase_q <= 1'b1;
      addressed_q <= 1'b0;
      ext_q <= 1'b0;
    end else if (line.stop_det) begin
      addr_phase_q <= 1'b0;
      addressed_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      if (line.scl_rise && cnt_q < `IBC_FALL_DATA) begin
        shift_q <= {shift_q[6:0], line.sda_s};
      end
      if (line.scl_fall && skip_q) begin
        skip_q <= 1'b0;
      end else if (fall_ok) begin
        cnt_q <= n;
        if (n == `IBC_FALL_ACK) begin
          addr_phase_q <= 1'b0;
        end
        if (n == `IBC_FALL_DATA && slave_hit_now) begin
          addressed_q <= 1'b1;
          ext_q <= ext_match;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and stretch points
  assign irq_point = fall_ok & (master_q | addressed_q) & ~(addr_phase_q & ext_q) &
                     (((n == `IBC_FALL_DATA) & ~addr_phase_q & ~stretch_timing_select) |
                      ((n == `IBC_FALL_ACK) & (addr_phase_q | stretch_timing_select)));
  assign ext_point = fall_ok & (n == `IBC_FALL_DATA) & slave_hit_now & ext_match;
  assign stretch_evt = irq_point | ext_point;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= stretch_evt | (line.stop_det & stop_irq_enable & ~addr_match_wakeup);
    end
  end

  // The slave hold survives a same-cycle release so that a new stretch is not lost
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slv_hold_q <= 1'b0;
    end else if (!op_en || exit_req || line.start_det || line.stop_det) begin
      slv_hold_q <= 1'b0;
    end else if (stretch_evt && !master_q) begin
      slv_hold_q <= 1'b1;
    end else if (release_req) begin
      slv_hold_q <= 1'b0;
    end
  end

  // Acknowledge spans the 9th clock, from the 8th fall to the 9th fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else if (!op_en || exit_req || line.start_det || line.stop_det) begin
      ack_q <= 1'b0;
    end else if (fall_ok) begin
      if (n == `IBC_FALL_DATA) begin
        ack_q <= addr_phase_q ? slave_hit_now :
                 (ack_enable & (master_q | addressed_q));
      end else begin
        ack_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; the lines are open drain, so only the enables move
  always_comb begin
    scl_oe_d = slv_hold_q;
    sda_oe_d = ack_q;
    unique case (m_state_q)
      M_START: sda_oe_d = 1'b1;
      M_LOW: begin
        scl_oe_d = 1'b1;
        sda_oe_d = ack_q | skip_q;
      end
      M_STRETCH: scl_oe_d = 1'b1;
      // Data is let go first so the rising clock cannot frame a stop
      M_RESTART: scl_oe_d = ~line.sda_s;
      M_STOP_L: begin
        scl_oe_d = 1'b1;
        sda_oe_d = 1'b1;
      end
      M_STOP_H: sda_oe_d = 1'b1;
      M_IDLE, M_HIGH: begin
        scl_oe_d = slv_hold_q;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      pin_low_q <= 1'b0;
    end else begin
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      pin_low_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = rdata_q;
  assign scl_out = pin_low_q;
  assign sda_out = pin_low_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign irq = irq_q;
  assign bus_busy_flag = busy_q;
  assign start_clear_flag = start_clear_q;
  assign master_state = master_q;

endmodule

`default_nettype wire

// >>> ibc_bus_ctrl_sva.sv
// Port-level assertions for the bus condition control block
`default_nettype none

`include "ibc_regs.svh"

module ibc_bus_ctrl_sva #(
  parameter int HALF_CYC = `IBC_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire ibc_pkg::ibc_byte_type reg_wdata,
  input wire ibc_pkg::ibc_byte_type reg_rdata,
  input wire ibc_pkg::ibc_addr_type own_address,
  input wire logic addr_match_wakeup,
  input wire logic reservation_disable,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic irq,
  input wire logic bus_busy_flag,
  input wire logic start_clear_flag,
  input wire logic master_state
);
  import ibc_pkg::*;
  // A stop written early waits for the next stretch, up to a whole byte later
  localparam int STOP_WIN = (24 * HALF_CYC > 1000) ? 1000 : 24 * HALF_CYC;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////////////
  property p_readback;
    reg_wr_en ##1 !reg_wr_en |-> ##1
      (reg_rdata & `IBC_CTL0_STORED) == ($past(reg_wdata, 2) & `IBC_CTL0_STORED);
  endproperty
  a_readback: assert property (p_readback) else $error("stored bits mismatch");

  property p_reads_zero;
    reg_rdata[6:5] == 2'h0 && reg_rdata[1:0] == 2'h0;
  endproperty
  a_reads_zero: assert property (p_reads_zero) else $error("action bit read as one");

  property p_start_launch;
    reg_wr_en && reg_wdata[1] && !reg_wdata[0] && reg_rdata[7] && !bus_busy_flag
      && !master_state && scl_in && sda_in |-> ##[1:12] master_state;
  endproperty
  a_start_launch: assert property (p_start_launch) else $error("no start on free bus");

  property p_refuse;
    reg_wr_en && reg_wdata[1] && reg_rdata[7] && bus_busy_flag && reservation_disable
      && !master_state |-> ##[1:2] (start_clear_flag && !master_state);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused start not flagged");

  property p_stop_mask;
    $fell(bus_busy_flag) && addr_match_wakeup |-> (!irq && !$past(irq)) ##1 !irq;
  endproperty
  a_stop_mask: assert property (p_stop_mask) else $error("stop irq while masked");

  property p_stop_irq;
    $fell(bus_busy_flag) && reg_rdata[4] && reg_rdata[7] && $past(reg_rdata[7])
      && !addr_match_wakeup |-> (irq || $past(irq) || $past(irq, 2)) or ##[1:2] irq;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stop irq missing");

  property p_stretch_hold;
    irq && master_state && scl_oe ##1 (!reg_wr_en) [*3] |-> scl_oe;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("stretch dropped");

  property p_stop_ends;
    reg_wr_en && reg_wdata[0] && !reg_wdata[1] && master_state && reg_rdata[7]
      |-> ##[1:STOP_WIN] !master_state;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop did not end master");
endmodule

bind ibc_bus_ctrl ibc_bus_ctrl_sva #(.HALF_CYC(HALF_CYC)) u_ibc_bus_ctrl_sva (
  .ref_clk, .rst_n, .reg_wr_en, .reg_wdata, .reg_rdata, .own_address,
  .addr_match_wakeup, .reservation_disable, .scl_in, .sda_in, .scl_out, .scl_oe,
  .sda_out, .sda_oe, .irq, .bus_busy_flag, .start_clear_flag, .master_state
);

`default_nettype wire

// >>> ibc_far_end.sv
// Far side of the bus: another master or slave, with pull-ups on both lines
`default_nettype none

module ibc_far_end (
  input wire logic dut_scl_oe,
  input wire logic dut_sda_oe,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic far_scl_oe = 1'b0;
  logic far_sda_oe = 1'b0;
  logic ack_seen = 1'b1;

  // Wired-AND with pull-ups: a released line reads high, never a stale level
  assign scl_in = !(dut_scl_oe || far_scl_oe);
  assign sda_in = !(dut_sda_oe || far_sda_oe);

  task automatic start_cond();
    far_sda_oe = 1'b1;
    #160;
    far_scl_oe = 1'b1;
    #160;
  endtask

  // Eight bits then the acknowledge clock; the clock is left held low afterwards
  task automatic send_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      far_sda_oe = (i > 0) ? !b[i-1] : 1'b0;
      #80;
      far_scl_oe = 1'b0;
      #80;
      ack_seen = sda_in;
      #80;
      far_scl_oe = 1'b1;
      #80;
    end
  endtask

  // Waits for any stretch on the clock before raising data
  task automatic stop_cond();
    far_sda_oe = 1'b1;
    #80;
    far_scl_oe = 1'b0;
    wait (scl_in === 1'b1);
    #160;
    far_sda_oe = 1'b0;
    #160;
  endtask
endmodule

`default_nettype wire

// >>> ibc_line_if.sv
// Synchronised bus line levels and detected events, passed from sensing to control
`default_nettype none

interface ibc_line_if;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  modport sense (
    output scl_s,
    output sda_s,
    output scl_rise,
    output scl_fall,
    output start_det,
    output stop_det
  );

  modport ctrl (
    input scl_s,
    input sda_s,
    input scl_rise,
    input scl_fall,
    input start_det,
    input stop_det
  );
endinterface

`default_nettype wire

// >>> ibc_line_sense.sv
// Two-stage synchronisers and edge, start and stop detection on the bus lines
`default_nettype none

module ibc_line_sense (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  ibc_line_if.sense line
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus is high, so the synchronisers reset high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign line.scl_s = scl_sync_q[1];
  assign line.sda_s = sda_sync_q[1];
  assign line.scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign line.scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign line.start_det = scl_sync_q[1] & scl_prev_q & ~sda_sync_q[1] & sda_prev_q;
  assign line.stop_det = scl_sync_q[1] & scl_prev_q & sda_sync_q[1] & ~sda_prev_q;

endmodule

`default_nettype wire

// >>> ibc_pkg.sv
// Types shared by the bus condition control modules
`default_nettype none

package ibc_pkg;

  typedef logic [7:0] ibc_byte_type;

  typedef logic [6:0] ibc_addr_type;

  typedef enum logic [2:0] {
    M_IDLE    = 3'h0,
    M_START   = 3'h1,
    M_LOW     = 3'h3,
    M_HIGH    = 3'h2,
    M_STRETCH = 3'h6,
    M_STOP_L  = 3'h7,
    M_STOP_H  = 3'h5,
    M_RESTART = 3'h4
  } ibc_mstate_type;

endpackage

`default_nettype wire

// >>> ibc_regs.svh
// Bit positions, reset values and timing counts of the bus condition control block
`ifndef IBC_REGS_SVH
`define IBC_REGS_SVH

`define IBC_CTL0_RESET 8'h00
`define IBC_BIT_ENABLE 7
`define IBC_BIT_EXIT 6
`define IBC_BIT_RELEASE 5
`define IBC_BIT_STOP_IRQ 4
`define IBC_BIT_STRETCH 3
`define IBC_BIT_ACK 2
`define IBC_BIT_START 1
`define IBC_BIT_STOP 0
`define IBC_CTL0_STORED 8'h9c

`define IBC_CLK_NS 40
`define IBC_SCL_HALF_NS 5000
`define IBC_HALF_CYC ((`IBC_SCL_HALF_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)

`define IBC_FALL_DATA 4'h8
`define IBC_FALL_ACK 4'h9
`define IBC_EXT_CODE 5'h1e

`endif

// >>> tb_top.sv
// Self-checking bench for the bus condition control block
`default_nettype none

`include "ibc_regs.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ibc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  ibc_byte_type reg_wdata = 8'h00;
  ibc_byte_type reg_rdata;
  ibc_addr_type own_address = 7'h2a;
  logic addr_match_wakeup = 1'b0;
  logic reservation_disable = 1'b0;
  logic scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe, irq;
  logic bus_busy_flag, start_clear_flag, master_state;
  int n_errors = 0;
  int samples_checked = 0;
  int irq_cnt = 0;

  ibc_bus_ctrl #(.HALF_CYC(8)) u_ibc_bus_ctrl (
    .ref_clk, .rst_n, .reg_wr_en, .reg_wdata, .reg_rdata, .own_address,
    .addr_match_wakeup, .reservation_disable, .scl_in, .sda_in, .scl_out, .scl_oe,
    .sda_out, .sda_oe, .irq, .bus_busy_flag, .start_clear_flag, .master_state
  );
  ibc_far_end u_ibc_far_end (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl_in, .sda_in);

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input ibc_byte_type b);
    tick(1);
    reg_wr_en = 1'b1;
    reg_wdata = b;
    tick(1);
    reg_wr_en = 1'b0;
  endtask

  // Config bits may only change with operation disabled
  task automatic cfg(input ibc_byte_type b);
    wr(8'h00);
    wr(b);
  endtask

  // Falls of the clock line until the next interrupt; a start adds its own fall
  task automatic count_falls(input logic [7:0] exp);
    logic [7:0] n;
    logic prev;
    n = 8'h00;
    prev = scl_in;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) begin
      tick(1);
      if (prev && !scl_in) n++;
      prev = scl_in;
    end
    chk("irq_reached", 8'h01, {7'h00, irq});
    chk("scl_falls", exp, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    wr(8'h1c);
    tick(2);
    chk("rdata_stored", 8'h1c, reg_rdata);
    wr(8'h7e);
    tick(2);
    chk("rdata_actions", 8'h1c, reg_rdata);
    chk("master_disabled", 8'h00, {7'h00, master_state});
  endtask

  task automatic t_slave();
    cfg(8'h80);
    u_ibc_far_end.start_cond();
    u_ibc_far_end.send_byte({own_address, 1'b0});
    chk("ack_level", 8'h00, {7'h00, u_ibc_far_end.ack_seen});
    tick(6);
    chk("slave_hold", 8'h01, {7'h00, scl_oe});
    chk("pin_value", 8'h00, {6'h00, scl_out, sda_out});
    wr(8'ha0);
    u_ibc_far_end.stop_cond();
  endtask

  task automatic t_stop_irq(input logic wake, input logic [7:0] exp);
    int n0;
    cfg(8'h90);
    addr_match_wakeup = wake;
    n0 = irq_cnt;
    u_ibc_far_end.start_cond();
    u_ibc_far_end.stop_cond();
    tick(10);
    chk("stop_irq_count", exp, 8'(irq_cnt - n0));
    addr_match_wakeup = 1'b0;
  endtask

  task automatic t_refuse();
    cfg(8'h80);
    reservation_disable = 1'b1;
    u_ibc_far_end.start_cond();
    wr(8'h82);
    tick(3);
    chk("start_clear_flag", 8'h01, {7'h00, start_clear_flag});
    u_ibc_far_end.stop_cond();
    tick(40);
    chk("no_late_start", 8'h00, {7'h00, master_state});
    reservation_disable = 1'b0;
  endtask

  task automatic t_reserve();
    cfg(8'h80);
    u_ibc_far_end.start_cond();
    wr(8'h82);
    tick(20);
    chk("reserved_wait", 8'h00, {7'h00, master_state});
    chk("busy_while_other", 8'h01, {7'h00, bus_busy_flag});
    u_ibc_far_end.stop_cond();
    count_falls(8'h0a);
    chk("reserved_start", 8'h01, {7'h00, master_state});
    wr(8'h81);
    tick(300);
    chk("stop_ends_master", 8'h00, {7'h00, master_state});
  endtask

  task automatic t_master();
    int n0;
    cfg(8'h90);
    wr(8'h92);
    count_falls(8'h0a);
    chk("rdata_after_start", 8'h90, reg_rdata);
    chk("master_after_start", 8'h01, {7'h00, master_state});
    wr(8'hb4);
    count_falls(8'h08);
    tick(1);
    chk("ack_drive", 8'h01, {7'h00, sda_oe});
    wr(8'hb8);
    count_falls(8'h01);
    wr(8'h92);
    count_falls(8'h0a);
    wr(8'hb8);
    count_falls(8'h09);
    tick(2);
    chk("no_ack", 8'h00, {7'h00, sda_oe});
    n0 = irq_cnt;
    wr(8'h99);
    tick(300);
    chk("master_after_stop", 8'h00, {7'h00, master_state});
    chk("stop_irq", 8'h01, 8'(irq_cnt - n0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    chk("rdata_reset", `IBC_CTL0_RESET, reg_rdata);
    t_regs();
    t_slave();
    t_stop_irq(1'b1, 8'h00);
    t_stop_irq(1'b0, 8'h01);
    t_refuse();
    t_reserve();
    t_master();
    wrap_up();
  end

  // Whole run is well under a millisecond of bus traffic
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
